// >>> verilog/bfce_pkg.sv
// Constants and types shared by the branch and flag clear execute block
package bfce_pkg;
	localparam int          BFCE_WORD_W        = 32;
	localparam int          BFCE_INSN_W        = 16;
	// Opcode patterns (upper byte for short branches, upper nibble for relative jump)
	localparam logic [7:0]  BFCE_OP_BF_DELAYED = 8'h8f;
	localparam logic [7:0]  BFCE_OP_BT         = 8'h89;
	localparam logic [7:0]  BFCE_OP_BT_DELAYED = 8'h8d;
	localparam logic [7:0]  BFCE_OP_BF         = 8'h8b;
	localparam logic [3:0]  BFCE_OP_REL_JUMP   = 4'ha;
	localparam logic [3:0]  BFCE_OP_REG_HI     = 4'h0;
	localparam logic [7:0]  BFCE_OP_REG_LO     = 8'h23;
	localparam logic [15:0] BFCE_OP_CLR_ACCUM  = 16'h0028;
	localparam logic [15:0] BFCE_OP_CLR_OVF    = 16'h0048;
	localparam logic [15:0] BFCE_OP_CLR_COND   = 16'h0008;
	// Branch arithmetic
	localparam logic [31:0] BFCE_PC_AHEAD      = 32'h0000_0004;
	localparam logic [31:0] BFCE_PC_STEP       = 32'h0000_0002;
	// Status word layout
	localparam int          BFCE_SR_COND_POS   = 0;
	localparam int          BFCE_SR_OVF_POS    = 1;
	localparam int          BFCE_SR_MASK_POS   = 4;
	localparam int          BFCE_SR_Q_POS      = 8;
	localparam int          BFCE_SR_M_POS      = 9;
	// Reset values
	localparam logic [31:0] BFCE_PC_RESET      = 32'h0000_0000;

	typedef enum logic [2:0] {
		BFCE_CLS_NONE,
		BFCE_CLS_COND_NOW,
		BFCE_CLS_COND_DELAYED,
		BFCE_CLS_UNCOND_DELAYED,
		BFCE_CLS_OTHER_BRANCH,
		BFCE_CLS_CLEAR
	} bfce_class_type;
endpackage : bfce_pkg

// >>> verilog/bfce_decode.sv
// Combinational opcode decoder and target adder
`timescale 1ns/1ps
module bfce_decode (
	input  wire logic [15:0]          insn,
	input  wire logic [31:0]          insn_addr,
	input  wire logic [31:0]          reg_value,
	output bfce_pkg::bfce_class_type  insn_class,
	output logic                      branch_if_true,
	output logic [31:0]               target
);
	import bfce_pkg::*;

	function automatic logic [31:0] rel_target(input logic [31:0] base, input logic [31:0] disp);
		rel_target = base + BFCE_PC_AHEAD + (disp << 1);
	endfunction : rel_target

	always_comb begin
		insn_class     = BFCE_CLS_NONE;
		branch_if_true = 1'b0;
		target         = insn_addr + BFCE_PC_STEP;
		if (insn[15:8] == BFCE_OP_BT || insn[15:8] == BFCE_OP_BF) begin
			insn_class     = BFCE_CLS_COND_NOW;
			branch_if_true = (insn[15:8] == BFCE_OP_BT);
			target         = rel_target(insn_addr, {{24{insn[7]}}, insn[7:0]});
		end else if (insn[15:8] == BFCE_OP_BT_DELAYED || insn[15:8] == BFCE_OP_BF_DELAYED) begin
			insn_class     = BFCE_CLS_COND_DELAYED;
			branch_if_true = (insn[15:8] == BFCE_OP_BT_DELAYED);
			target         = rel_target(insn_addr, {{24{insn[7]}}, insn[7:0]});
		end else if (insn[15:12] == BFCE_OP_REL_JUMP) begin
			insn_class = BFCE_CLS_UNCOND_DELAYED;
			target     = rel_target(insn_addr, {{20{insn[11]}}, insn[11:0]});
		end else if (insn[15:12] == BFCE_OP_REG_HI && insn[7:0] == BFCE_OP_REG_LO) begin
			insn_class = BFCE_CLS_UNCOND_DELAYED;
			target     = insn_addr + BFCE_PC_AHEAD + reg_value;
		end else if (insn == BFCE_OP_CLR_ACCUM || insn == BFCE_OP_CLR_OVF
				|| insn == BFCE_OP_CLR_COND) begin
			insn_class = BFCE_CLS_CLEAR;
		end
	end
endmodule : bfce_decode

// >>> verilog/bfce_exec.sv
// Execute stage for branches and flag or accumulator clears
`timescale 1ns/1ps
module bfce_exec (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        clk_en,
	input  wire logic        insn_valid,
	input  wire logic [15:0] insn,
	input  wire logic [31:0] general_reg_n,
	output logic [3:0]       reg_select,
	output logic [31:0]      pc,
	output logic [31:0]      processor_state_word,
	output logic [31:0]      accum_high,
	output logic [31:0]      accum_low,
	output logic             in_delay_slot,
	output logic             irq_hold,
	output logic             slot_illegal
);
	import bfce_pkg::*;

	typedef struct packed {
		logic [31:0] pc;
		logic [31:0] pending_target;
		logic        pending_take;
		logic        slot;
		logic        cond_flag;
		logic        ovf_limit;
		logic [31:0] accum_high;
		logic [31:0] accum_low;
		logic        slot_illegal;
	} bfce_state_type;

	bfce_state_type  state;
	bfce_state_type  next_state;
	bfce_class_type  insn_class;
	logic            branch_if_true;
	logic [31:0]     target;
	logic            cond_met;

	assign reg_select = insn[11:8];

	bfce_decode u_decode (
		.insn           (insn),
		.insn_addr      (state.pc),
		.reg_value      (general_reg_n),
		.insn_class     (insn_class),
		.branch_if_true (branch_if_true),
		.target         (target)
	);

	assign cond_met = (state.cond_flag == branch_if_true);

	always_comb begin
		next_state              = state;
		next_state.slot_illegal = 1'b0;
		if (insn_valid) begin
			next_state.pc   = state.pc + BFCE_PC_STEP;
			next_state.slot = 1'b0;
			next_state.pending_take = 1'b0;
			if (state.slot) begin
				if (state.pending_take) begin
					next_state.pc = state.pending_target;
				end
				if (insn_class == BFCE_CLS_COND_NOW || insn_class == BFCE_CLS_COND_DELAYED
						|| insn_class == BFCE_CLS_UNCOND_DELAYED) begin
					next_state.slot_illegal = 1'b1;
				end
			end else begin
				case (insn_class)
					BFCE_CLS_COND_NOW: begin
						if (cond_met) begin
							next_state.pc = target;
						end
					end
					BFCE_CLS_COND_DELAYED: begin
						next_state.slot           = 1'b1;
						next_state.pending_take   = cond_met;
						next_state.pending_target = target;
					end
					BFCE_CLS_UNCOND_DELAYED: begin
						next_state.slot           = 1'b1;
						next_state.pending_take   = 1'b1;
						next_state.pending_target = target;
					end
					default: begin
					end
				endcase
			end
			if (!next_state.slot_illegal && insn_class == BFCE_CLS_CLEAR) begin
				if (insn == BFCE_OP_CLR_ACCUM) begin
					next_state.accum_high = '0;
					next_state.accum_low  = '0;
				end
				if (insn == BFCE_OP_CLR_OVF) begin
					next_state.ovf_limit = 1'b0;
				end
				if (insn == BFCE_OP_CLR_COND) begin
					next_state.cond_flag = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state      <= '0;
			state.pc   <= BFCE_PC_RESET;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	always_comb begin
		processor_state_word                   = '0;
		processor_state_word[BFCE_SR_COND_POS] = state.cond_flag;
		processor_state_word[BFCE_SR_OVF_POS]  = state.ovf_limit;
	end

	assign pc            = state.pc;
	assign accum_high    = state.accum_high;
	assign accum_low     = state.accum_low;
	assign in_delay_slot = state.slot;
	assign irq_hold      = state.slot;
	assign slot_illegal  = state.slot_illegal;

	// Clock enable is part of the issue, so a frozen edge never starts a pair
	sequence s_delayed_issue;
		clk_en && insn_valid && !state.slot && insn_class == BFCE_CLS_UNCOND_DELAYED;
	endsequence

	sequence s_cond_delayed_issue;
		clk_en && insn_valid && !state.slot && insn_class == BFCE_CLS_COND_DELAYED;
	endsequence

	sequence s_slot_issue;
		clk_en && insn_valid && state.slot;
	endsequence

	// Target reached after the slot
	a_delayed_slot_order: assert property (@(posedge ref_clk) disable iff (reset)
		s_delayed_issue ##1 (clk_en && insn_valid)
		|=> pc == $past(state.pending_target))
		else $error("Delayed branch did not land on target after slot");

	a_slot_addr_step: assert property (@(posedge ref_clk) disable iff (reset)
		s_delayed_issue |=> pc == $past(pc) + 32'h0000_0002)
		else $error("Slot not at branch address plus two");

	a_irq_hold_slot: assert property (@(posedge ref_clk) disable iff (reset)
		s_delayed_issue |=> irq_hold)
		else $error("Interrupts not held after delayed branch");

	a_cond_irq_hold: assert property (@(posedge ref_clk) disable iff (reset)
		s_cond_delayed_issue |=> irq_hold && in_delay_slot)
		else $error("Interrupts not held after conditional delayed branch");

	a_cond_slot_step: assert property (@(posedge ref_clk) disable iff (reset)
		s_cond_delayed_issue |=> pc == $past(pc) + 32'h0000_0002)
		else $error("Conditional slot not at branch address plus two");

	a_cond_taken_land: assert property (@(posedge ref_clk) disable iff (reset)
		s_cond_delayed_issue ##1 (s_slot_issue and state.pending_take)
		|=> pc == $past(state.pending_target))
		else $error("Taken conditional delayed branch missed its target");

	a_cond_fall_through: assert property (@(posedge ref_clk) disable iff (reset)
		s_cond_delayed_issue ##1 (s_slot_issue and !state.pending_take)
		|=> pc == $past(pc) + 32'h0000_0002)
		else $error("Not-taken conditional delayed branch left the line");

	a_slot_bfs_bad: assert property (@(posedge ref_clk) disable iff (reset)
		s_slot_issue and (insn[15:8] == BFCE_OP_BF_DELAYED) |=> slot_illegal)
		else $error("Delayed branch-on-false in slot not flagged illegal");

	a_illegal_pulse: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && slot_illegal |=> !slot_illegal)
		else $error("Slot illegal flag stood longer than one cycle");

	// Frozen edges must leave the counter alone
	a_freeze_pc: assert property (@(posedge ref_clk) disable iff (reset)
		!clk_en |=> pc == $past(pc))
		else $error("Program counter moved with clock enable low");

	a_status_spare: assert property (@(posedge ref_clk) disable iff (reset)
		processor_state_word[31:2] == 30'h0)
		else $error("Unused status bits not zero");

	a_slot_branch_bad: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && insn_valid && state.slot && insn_class != BFCE_CLS_NONE
		&& insn_class != BFCE_CLS_CLEAR |=> slot_illegal)
		else $error("Branch in slot not flagged illegal");

	a_bt_not_taken: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && insn_valid && !state.slot && insn[15:8] == 8'h89 && !state.cond_flag
		|=> pc == $past(pc) + 32'h0000_0002)
		else $error("Branch-on-true taken with flag clear");

	a_bt_taken_target: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && insn_valid && !state.slot && insn[15:8] == 8'h89 && state.cond_flag
		|=> pc == $past(pc) + 32'h4 + {{23{$past(insn[7])}}, $past(insn[7:0]), 1'b0})
		else $error("Short branch target wrong");

	a_clear_accum: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && insn_valid && !state.slot && insn == 16'h0028
		|=> accum_high == '0 && accum_low == '0 && $stable(processor_state_word[0]))
		else $error("Accumulator clear failed");

	a_clear_ovf: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && insn_valid && !state.slot && insn == 16'h0048
		|=> !processor_state_word[1] && $stable(processor_state_word[0]))
		else $error("Overflow-limit clear failed");

	a_clear_cond: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && insn_valid && !state.slot && insn == 16'h0008 |=> !processor_state_word[0])
		else $error("Condition flag clear failed");
endmodule : bfce_exec

// >>> testbench/bfce_regfile_model.sv
// Register file model standing at the far side of the execute block
`timescale 1ns/1ps
module bfce_regfile_model (
	input  wire logic [3:0]  reg_select,
	output logic      [31:0] general_reg_n
);
	// A distinct value per register, so a wrong select lands on a wrong target
	assign general_reg_n = {4'h0, reg_select, 24'h00_0010};
endmodule : bfce_regfile_model

// >>> testbench/branch_and_flag_clear_exec_test.sv
// Self-checking bench for the branch and flag clear execute block
`timescale 1ns/1ps
module branch_and_flag_clear_exec_test;
	import bfce_pkg::*;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic        clk_en = 1'b1;
	logic        insn_valid = 1'b0;
	logic [15:0] insn = 16'h0000;
	logic [31:0] general_reg_n, pc, processor_state_word, accum_high, accum_low, exp_pc;
	logic [3:0]  reg_select;
	logic        in_delay_slot, irq_hold, slot_illegal;
	int          num_errors = 0;
	int          n_tests = 0;

	always #25 ref_clk = ~ref_clk;

	bfce_exec i_dut (
		.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .insn_valid(insn_valid),
		.insn(insn), .general_reg_n(general_reg_n), .reg_select(reg_select), .pc(pc),
		.processor_state_word(processor_state_word), .accum_high(accum_high),
		.accum_low(accum_low), .in_delay_slot(in_delay_slot), .irq_hold(irq_hold),
		.slot_illegal(slot_illegal)
	);
	bfce_regfile_model i_model (.reg_select(reg_select), .general_reg_n(general_reg_n));

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Inputs move 1 ns after the edge; valid stays up so steps run back to back
	task step(input logic [15:0] w);
		insn = w;
		insn_valid = 1'b1;
		@(posedge ref_clk);
		#1;
	endtask : step

	task delayed(input logic [15:0] br, input logic [15:0] slot, input logic [31:0] tgt,
		input logic ill);
		step(br);
		check("pc_slot", pc, exp_pc + BFCE_PC_STEP);
		check("irq_hold", {31'h0, irq_hold}, 32'h1);
		step(slot);
		check("pc_target", pc, tgt);
		check("slot_illegal", {31'h0, slot_illegal}, {31'h0, ill});
		exp_pc = tgt;
	endtask : delayed

	task t_reset;
		exp_pc = BFCE_PC_RESET;
		check("pc_reset", pc, exp_pc);
		check("state_reset", processor_state_word, 32'h0);
	endtask : t_reset

	task t_clears;
		step(BFCE_OP_CLR_ACCUM);
		exp_pc = exp_pc + BFCE_PC_STEP;
		check("accum_high", accum_high, 32'h0);
		check("accum_low", accum_low, 32'h0);
		step(BFCE_OP_CLR_OVF);
		check("state_ovf", processor_state_word, 32'h0);
		step(BFCE_OP_CLR_COND);
		exp_pc = exp_pc + 32'h4;
		check("state_cond", processor_state_word, 32'h0);
		check("pc_clears", pc, exp_pc);
	endtask : t_clears

	// Disabled clock enable must freeze the program counter
	task t_freeze;
		clk_en = 1'b0;
		step(BFCE_OP_CLR_COND);
		clk_en = 1'b1;
		check("pc_frozen", pc, exp_pc);
	endtask : t_freeze

	// Flag is zero after reset, so branch-on-true falls through
	task t_branch_true;
		step({BFCE_OP_BT, 8'h7f});
		exp_pc = exp_pc + BFCE_PC_STEP;
		check("pc_bt", pc, exp_pc);
	endtask : t_branch_true

	task t_conditional_delayed;
		delayed({BFCE_OP_BF_DELAYED, 8'h80}, BFCE_OP_CLR_COND, exp_pc + 32'h4 - 32'h100,
			1'b0);
		delayed({BFCE_OP_BT_DELAYED, 8'h7f}, BFCE_OP_CLR_ACCUM, exp_pc + 32'h4, 1'b0);
	endtask : t_conditional_delayed

	task t_jumps;
		delayed({BFCE_OP_REL_JUMP, 12'h7ff}, BFCE_OP_CLR_COND, exp_pc + 32'h4 + 32'hffe,
			1'b0);
		delayed({BFCE_OP_REL_JUMP, 12'h800}, BFCE_OP_CLR_COND, exp_pc + 32'h4 - 32'h1000,
			1'b0);
		delayed({BFCE_OP_REG_HI, 4'h5, BFCE_OP_REG_LO}, BFCE_OP_CLR_COND,
			exp_pc + 32'h4 + 32'h0500_0010, 1'b0);
	endtask : t_jumps

	// A branch in a slot is refused and flagged for one cycle only
	task t_illegal;
		delayed(16'ha000, {BFCE_OP_BT, 8'h10}, exp_pc + 32'h4, 1'b1);
		delayed(16'ha000, {BFCE_OP_BF_DELAYED, 8'h10}, exp_pc + 32'h4, 1'b1);
		step(BFCE_OP_CLR_COND);
		exp_pc = exp_pc + BFCE_PC_STEP;
		check("illegal_pulse", {31'h0, slot_illegal}, 32'h0);
		check("pc_after", pc, exp_pc);
	endtask : t_illegal

	task summarize;
		if (num_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize

	initial begin
		repeat (8) @(posedge ref_clk);
		#1;
		reset = 1'b0;
		t_reset();
		t_clears();
		t_freeze();
		t_branch_true();
		t_conditional_delayed();
		t_jumps();
		t_illegal();
		summarize();
	end

	// About 30 cycles of work; 2000 cycles means a hang
	initial begin
		#100us;
		num_errors++;
		summarize();
	end
endmodule : branch_and_flag_clear_exec_test
